// File: wwd_pkg.sv
// Package with the register map, field layout, reset values and timing counts of the watchdog.
package wwd_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS   = 20;
  localparam int unsigned PRESCALE_CYCLES = 16384;
  localparam int unsigned RST_TIME_NS     = 30000;
  localparam int unsigned RST_CYCLES      = (RST_TIME_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                            (RST_TIME_NS / CLK_PERIOD_NS);

  // ==========================================================================
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL_CNT  = 8'h00;
  localparam logic [7:0] ADDR_WINDOW    = 8'h04;
  localparam logic [7:0] ADDR_STATUS    = 8'h08;
  localparam logic [7:0] ADDR_IRQ_EN    = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_CLR   = 8'h10;
  localparam logic [7:0] ADDR_TOUT_MIN  = 8'h14;
  localparam logic [7:0] ADDR_TOUT_MAX  = 8'h18;

  // ==========================================================================
  // Fields and reset values
  localparam int unsigned CNT_W         = 7;
  localparam int unsigned ACT_BIT       = 7;
  localparam int unsigned TOP_BIT       = 6;
  localparam int unsigned EVT_W         = 4;
  localparam int unsigned EVT_TIMEOUT   = 0;
  localparam int unsigned EVT_WINDOW    = 1;
  localparam int unsigned EVT_SOFTWARE  = 2;
  localparam int unsigned EVT_HALT      = 3;
  localparam int unsigned STAT_BUSY_BIT = 7;
  localparam logic [6:0]  CNT_RST       = 7'h7f;
  localparam logic [6:0]  WIN_RST       = 7'h7f;
  localparam logic [6:0]  CNT_EXPIRE    = 7'h40;
  localparam logic [5:0]  LOAD_RST      = 6'h3f;

  // ==========================================================================
  // Timeout formula constants; TB_MSB and TB_LSB are indexed by the timebase selection
  localparam logic [31:0] TMAX0_BASE    = 32'h0000_4000;
  localparam logic [31:0] PRE_STEP      = 32'h0000_4000;
  localparam logic [31:0] MIN_OFFSET    = 32'h0000_0080;
  localparam logic [31:0] EXTRA_OFFSET  = 32'h0000_00c0;
  localparam logic [31:0] OFFSET_SCALE  = 32'h0000_0040;
  localparam logic [7:0]  TB_MSB [4]    = '{8'h04, 8'h08, 8'h14, 8'h31};
  localparam logic [7:0]  TB_LSB [4]    = '{8'h3b, 8'h35, 8'h23, 8'h36};

  // ==========================================================================
  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : wwd_pkg

// File: wwd_prescaler.sv
// Free-running divider that emits one tick per prescale period.
`timescale 1ns/10ps
`default_nettype none
module wwd_prescaler #(
  parameter int unsigned DIV = 16384
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Tick
  output logic      tick
);
  localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_ff;

  // ==========================================================================
  // Divider
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff <= '0;
    end else if (cnt_ff == LAST) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  assign tick = (cnt_ff == LAST);

endmodule : wwd_prescaler
`default_nettype wire

// File: wwd_reset_pulse.sv
// Stretches a reset request into a fixed-length active-low reset pulse.
`timescale 1ns/10ps
`default_nettype none
module wwd_reset_pulse #(
  parameter int unsigned LEN = 1500
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Request and pulse
  input  wire logic start,
  output logic      busy,
  output logic      rst_out_n
);
  localparam int unsigned CW = $clog2(LEN + 1);
  localparam logic [CW-1:0] FULL = CW'(LEN);

  logic [CW-1:0] left_ff;

  // ==========================================================================
  // Pulse counter
  // A request during a running pulse is absorbed: the pulse is not lengthened.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      left_ff   <= '0;
      rst_out_n <= 1'b1;
    end else if (left_ff != '0) begin
      left_ff   <= left_ff - 1'b1;
      rst_out_n <= (left_ff == CW'(1));
    end else if (start) begin
      left_ff   <= FULL;
      rst_out_n <= 1'b0;
    end
  end

  assign busy = (left_ff != '0);

endmodule : wwd_reset_pulse
`default_nettype wire

// File: wwd_window_watchdog_timer.sv
// Window watchdog timer with AXI4-Lite registers, reset pulse and event interrupt.
//
// Operation
// R01: Counter decrements once per 16384 oscillator cycles through a prescaler.
// R02: Active watchdog and count rolling 40h to 3Fh starts a 30 us reset.
// R03: Counter rewrite while above the window value causes a reset.
// R04: Software refreshes only below window and above 3Fh.
// R05: Software writes C0h to FFh so the top counter bit is one.
// R06: Software option: disabled after reset, set-only activation bit.
// R07: Hardware option keeps the watchdog always active, activation bit ignored.
// R08: Downcounter keeps decrementing even while the watchdog is disabled.
// R09: Activation bit set with top counter bit zero gives immediate reset.
// R10: Active watchdog with halt-reset option turns HALT into a reset.
// R11: Software should refresh the counter just before HALT.
// R12: Lower six counter bits select one of 64 timeout steps.
// R13: Timeout spans min and max; bases 16384 and (offset+128)*64 periods.
// R14: Timebase selection picks correction constant pairs 4/59, 8/53, 20/35, 49/54.
// R15: All divisions in the timeout computation truncate downward.
// R16: Control-counter and window registers reset to 7Fh.
// R17: Window register holds a 7-bit value compared against the counter.
// R18: Control write loads seven counter bits and ORs in activation bit.
//
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module wwd_window_watchdog_timer
  import wwd_pkg::*;
#(
  parameter int unsigned PRESCALE = PRESCALE_CYCLES
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Option straps, from pins
  input  wire logic        hw_activation_option,
  input  wire logic        halt_reset_option,
  // CPU side, same clock
  input  wire logic [1:0]  timebase_select,
  input  wire logic        halt_request,
  output logic             halt_permit,
  // Reset cycle and interrupt
  output logic             wdg_reset_n,
  output logic             irq
);

  // ==========================================================================
  // Option synchronisers
  // A strap change is accepted only once the second and third stages agree.
  logic [1:0] opt_s1_ff;
  logic [1:0] opt_s2_ff;
  logic [1:0] opt_s3_ff;
  logic [1:0] opt_ff;
  logic [1:0] opt_in;

  assign opt_in = {halt_reset_option, hw_activation_option};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      opt_s1_ff <= '0;
      opt_s2_ff <= '0;
      opt_s3_ff <= '0;
    end else begin
      opt_s1_ff <= opt_in;
      opt_s2_ff <= opt_s1_ff;
      opt_s3_ff <= opt_s2_ff;
    end
  end

  for (genvar i = 0; i < 2; i++) begin : g_opt
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        opt_ff[i] <= 1'b0;
      end else if (opt_s2_ff[i] == opt_s3_ff[i]) begin
        opt_ff[i] <= opt_s2_ff[i];
      end
    end
  end

  // ==========================================================================
  // AXI4-Lite write path
  logic        aw_held_ff;
  logic        w_held_ff;
  logic [7:0]  waddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;
  logic        do_write;
  logic        wr_map;

  assign s_axi_awready = !aw_held_ff && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_ff && !s_axi_bvalid;
  assign do_write      = aw_held_ff && w_held_ff && !s_axi_bvalid;
  assign wr_map        = (waddr_ff == ADDR_CTRL_CNT) || (waddr_ff == ADDR_WINDOW) ||
                         (waddr_ff == ADDR_IRQ_EN) || (waddr_ff == ADDR_IRQ_CLR) ||
                         (waddr_ff == ADDR_STATUS) || (waddr_ff == ADDR_TOUT_MIN) ||
                         (waddr_ff == ADDR_TOUT_MAX);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff   <= 1'b0;
      w_held_ff    <= 1'b0;
      waddr_ff     <= '0;
      wdata_ff     <= '0;
      wstrb_ff     <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_ff <= 1'b1;
        waddr_ff   <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata;
        wstrb_ff  <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_ff   <= 1'b0;
        w_held_ff    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Only byte lane 0 carries register bits; other lanes are ignored.
  logic       wr_lane0;
  logic       wr_ctrl;
  logic       wr_win;
  logic       wr_en;
  logic       wr_clr;
  logic [7:0] wbyte;

  assign wr_lane0 = do_write && wstrb_ff[0];
  assign wr_ctrl  = wr_lane0 && (waddr_ff == ADDR_CTRL_CNT);
  assign wr_win   = wr_lane0 && (waddr_ff == ADDR_WINDOW);
  assign wr_en    = wr_lane0 && (waddr_ff == ADDR_IRQ_EN);
  assign wr_clr   = wr_lane0 && (waddr_ff == ADDR_IRQ_CLR);
  assign wbyte    = wdata_ff[7:0];

  // ==========================================================================
  // Watchdog core
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] win_ff;
  logic             act_ff;
  logic [5:0]       load_ff;
  logic             tick;
  logic             active;
  logic             nxt_active;
  logic [EVT_W-1:0] evt;
  logic             rst_busy;

  wwd_prescaler #(
    .DIV (PRESCALE)
  ) u_prescaler (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (tick)
  ); // R01

  assign active     = act_ff || opt_ff[0]; // R07
  assign nxt_active = active || wbyte[ACT_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff <= CNT_RST; // R16
    end else if (wr_ctrl) begin
      cnt_ff <= wbyte[CNT_W-1:0]; // R18
    end else if (tick) begin
      cnt_ff <= cnt_ff - 1'b1; // R01 R08
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act_ff <= 1'b0; // R06 R16
    end else if (wr_ctrl) begin
      act_ff <= act_ff | wbyte[ACT_BIT]; // R06 R18
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      win_ff <= WIN_RST; // R16
    end else if (wr_win) begin
      win_ff <= wbyte[CNT_W-1:0]; // R17
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      load_ff <= LOAD_RST;
    end else if (wr_ctrl) begin
      load_ff <= wbyte[5:0]; // R12
    end
  end

  assign evt[EVT_TIMEOUT]  = active && tick && !wr_ctrl && (cnt_ff == CNT_EXPIRE); // R02
  assign evt[EVT_WINDOW]   = active && wr_ctrl && (cnt_ff > win_ff); // R03 R17
  assign evt[EVT_SOFTWARE] = nxt_active && wr_ctrl && !wbyte[TOP_BIT]; // R09
  assign evt[EVT_HALT]     = active && opt_ff[1] && halt_request; // R10
  assign halt_permit       = halt_request && !evt[EVT_HALT];

  wwd_reset_pulse #(
    .LEN (RST_CYCLES)
  ) u_reset_pulse (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .start     (|evt),
    .busy      (rst_busy),
    .rst_out_n (wdg_reset_n)
  ); // R02

  // ==========================================================================
  // Timeout window in oscillator periods
  function automatic logic [31:0] timeout_calc(input logic [5:0] cnt,
                                               input logic [1:0] tb,
                                               input logic       is_max);
    logic [31:0] msb;
    logic [31:0] lsb;
    logic [31:0] c;
    logic [31:0] q;
    logic [31:0] base;
    logic        short;
    msb   = {24'h0, TB_MSB[tb]}; // R14
    lsb   = {24'h0, TB_LSB[tb]};
    c     = {26'h0, cnt};
    q     = (c << 2) / msb; // R15
    base  = is_max ? TMAX0_BASE : (lsb + MIN_OFFSET) * OFFSET_SCALE; // R13
    short = is_max ? (c <= (msb >> 2)) : (c < (msb >> 2));
    if (short) begin
      timeout_calc = base + PRE_STEP * c;
    end else begin
      timeout_calc = base + PRE_STEP * (c - q) + (EXTRA_OFFSET + lsb) * OFFSET_SCALE * q;
    end
  endfunction : timeout_calc

  logic [31:0] tmin_ff;
  logic [31:0] tmax_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tmin_ff <= '0;
      tmax_ff <= '0;
    end else begin
      tmin_ff <= timeout_calc(load_ff, timebase_select, 1'b0); // R13
      tmax_ff <= timeout_calc(load_ff, timebase_select, 1'b1); // R13
    end
  end

  // ==========================================================================
  // Interrupt status
  // A new event in the same cycle as its clear keeps the bit set.
  logic [EVT_W-1:0] stat_ff;
  logic [EVT_W-1:0] irq_en_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_ff <= '0;
    end else begin
      stat_ff <= (stat_ff & ~(wr_clr ? wbyte[EVT_W-1:0] : '0)) | evt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_en_ff <= '0;
    end else if (wr_en) begin
      irq_en_ff <= wbyte[EVT_W-1:0];
    end
  end

  assign irq = |(stat_ff & irq_en_ff);

  // ==========================================================================
  // AXI4-Lite read path
  logic [31:0] rmux;
  logic        rhit;

  always_comb begin
    rhit = 1'b1;
    unique case (s_axi_araddr)
      ADDR_CTRL_CNT: rmux = {24'h0, act_ff, cnt_ff};
      ADDR_WINDOW:   rmux = {24'h0, 1'b0, win_ff};
      ADDR_STATUS:   rmux = {24'h0, rst_busy, 3'h0, stat_ff};
      ADDR_IRQ_EN:   rmux = {28'h0, irq_en_ff};
      ADDR_IRQ_CLR:  rmux = '0;
      ADDR_TOUT_MIN: rmux = tmin_ff;
      ADDR_TOUT_MAX: rmux = tmax_ff;
      default: begin
        rmux = '0;
        rhit = 1'b0;
      end
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rmux;
      s_axi_rresp  <= rhit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : wwd_window_watchdog_timer
`default_nettype wire

// File: wwd_window_watchdog_timer_props.sv
// Port-level assertions for the window watchdog timer.
`timescale 1ns/10ps
`default_nettype none
module wwd_window_watchdog_timer_props
  import wwd_pkg::*;
(
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Halt and reset pulse
  input wire logic        halt_request,
  input wire logic        halt_permit,
  input wire logic        wdg_reset_n
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ==========
  // The pulse is far too long for a repetition, so its low cycles are counted here.
  int unsigned low_cnt_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn || wdg_reset_n) low_cnt_ff <= 0;
    else low_cnt_ff <= low_cnt_ff + 1;
  end

  pulse_len_a: assert property ($rose(wdg_reset_n) |-> low_cnt_ff == RST_CYCLES)
    else $error("reset pulse length wrong");
  pulse_max_a: assert property (low_cnt_ff <= RST_CYCLES)
    else $error("reset pulse too long");
  halt_gate_a: assert property (halt_permit |-> halt_request)
    else $error("halt permitted without request");
  halt_reset_a: assert property (halt_request && !halt_permit && wdg_reset_n
    |-> ##[1:2] !wdg_reset_n)
    else $error("blocked halt gave no reset");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken during answer");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write answer late");
endmodule : wwd_window_watchdog_timer_props

bind wwd_window_watchdog_timer wwd_window_watchdog_timer_props u_props (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .halt_request, .halt_permit, .wdg_reset_n
);
`default_nettype wire

// File: wwd_window_watchdog_timer_tb.sv
// Self-checking testbench for the window watchdog timer.
`timescale 1ns/10ps
`default_nettype none
module wwd_window_watchdog_timer_tb;
  import wwd_pkg::*;
  // A short prescale keeps the run small; every wait on the counter is derived from it.
  localparam int unsigned PS    = 16;
  localparam int          MS[4] = '{4, 8, 20, 49};
  localparam int          LS[4] = '{59, 53, 35, 54};
  // ==========
  // Design ports
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready = 1'b0;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready = 1'b0;
  logic        hw_activation_option = 1'b0;
  logic        halt_reset_option = 1'b0;
  logic [1:0]  timebase_select = 2'h0;
  logic        halt_request = 1'b0;
  logic        halt_permit;
  logic        wdg_reset_n;
  logic        irq;
  int          fails = 0;
  int          checks_done = 0;

  wwd_window_watchdog_timer #(.PRESCALE(PS)) u_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .hw_activation_option,
    .halt_reset_option, .timebase_select, .halt_request, .halt_permit, .wdg_reset_n, .irq
  );

  always #10 aclk = ~aclk;

  // ==========
  // Helpers
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic quit();
    fails++;
    end_sim();
  endtask : quit

  // Handshakes are judged at the falling edge so no decision races the rising-edge update.
  // Ready is raised only once valid is seen, so the slave must hold its answer a cycle.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic       ta, tw, bd, bv;
    logic [1:0] r;
    bd = 1'b0;
    bv = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (int i = 0; i < 50 && !bd; i++) begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      bd = s_axi_bvalid & s_axi_bready;
      bv = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      s_axi_bready <= bv & !bd;
    end
    if (!bd) quit();
    chk("bresp", er, r);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    logic       ta, rv, vv;
    logic [1:0] r;
    rv = 1'b0;
    vv = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (int i = 0; i < 50 && !rv; i++) begin
      @(negedge aclk);
      ta = s_axi_arvalid & s_axi_arready;
      rv = s_axi_rvalid & s_axi_rready;
      vv = s_axi_rvalid;
      r = s_axi_rresp;
      d = s_axi_rdata;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      s_axi_rready <= vv & !rv;
    end
    if (!rv) quit();
    chk("rresp", er, r);
  endtask : rd

  task automatic rst_dut();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
  endtask : rst_dut

  task automatic wait_rst(output int n);
    n = 0;
    while (wdg_reset_n !== 1'b0 && n < 4000) begin
      @(negedge aclk);
      n++;
    end
    if (n >= 4000) quit();
  endtask : wait_rst

  task automatic hpulse(input logic e);
    @(posedge aclk);
    halt_request <= 1'b1;
    @(negedge aclk);
    chk("permit", e, halt_permit);
    @(posedge aclk);
    halt_request <= 1'b0;
  endtask : hpulse

  function automatic logic [31:0] tcalc(input int t, input int c, input bit mx);
    int q, r;
    q = 4 * c / MS[t];
    r = mx ? 16384 : (LS[t] + 128) * 64;
    if (c < MS[t] / 4 || (mx && c == MS[t] / 4)) return r + 16384 * c;
    return r + 16384 * (c - q) + (192 + LS[t]) * 64 * q;
  endfunction : tcalc

  // ==========
  // Scenarios
  task automatic t_regs();
    logic [31:0] d, e;
    rd(ADDR_CTRL_CNT, RESP_OKAY, d);
    chk("ctrl", 32'h7f, d);
    rd(ADDR_WINDOW, RESP_OKAY, d);
    chk("win", 32'h7f, d);
    rd(8'h20, RESP_SLVERR, d);
    chk("unmapped", 32'h0, d);
    wr(8'h20, 32'h1, RESP_SLVERR);
    wr(ADDR_WINDOW, 32'hd5, RESP_OKAY);
    rd(ADDR_WINDOW, RESP_OKAY, d);
    chk("win", 32'h55, d);
    rd(ADDR_CTRL_CNT, RESP_OKAY, d);
    // The two samples lie exactly four prescale periods apart, whatever the phase.
    repeat (4 * PS - 4) @(posedge aclk);
    rd(ADDR_CTRL_CNT, RESP_OKAY, e);
    chk("count", d - 32'd4, e);
    repeat (64 * PS) @(posedge aclk);
    rd(ADDR_STATUS, RESP_OKAY, d);
    chk("status", 32'h0, d);
    $display("test regs done");
  endtask : t_regs

  task automatic t_tout();
    logic [31:0] d;
    int          n;
    rst_dut();
    wr(ADDR_CTRL_CNT, 32'hc3, RESP_OKAY);
    wait_rst(n);
    chk("tout", 32'h1, 32'(n >= 3 * PS - 2 && n <= 4 * PS + 4));
    rd(ADDR_STATUS, RESP_OKAY, d);
    chk("status", 32'h81, d);
    @(negedge aclk);
    chk("irq", 32'h0, irq);
    wr(ADDR_IRQ_EN, 32'h1, RESP_OKAY);
    @(negedge aclk);
    chk("irq", 32'h1, irq);
    wr(ADDR_IRQ_EN, 32'h2, RESP_OKAY);
    @(negedge aclk);
    chk("irq", 32'h0, irq);
    wr(ADDR_IRQ_EN, 32'h1, RESP_OKAY);
    wr(ADDR_IRQ_CLR, 32'h1, RESP_OKAY);
    @(negedge aclk);
    chk("irq", 32'h0, irq);
    repeat (RST_CYCLES) @(posedge aclk);
    @(negedge aclk);
    chk("pulse end", 32'h1, wdg_reset_n);
    $display("test timeout done");
  endtask : t_tout

  task automatic t_win();
    logic [31:0] d;
    int          n;
    rst_dut();
    wr(ADDR_WINDOW, 32'h70, RESP_OKAY);
    wr(ADDR_CTRL_CNT, 32'hff, RESP_OKAY);
    repeat (17 * PS) @(posedge aclk);
    wr(ADDR_CTRL_CNT, 32'hff, RESP_OKAY);
    rd(ADDR_STATUS, RESP_OKAY, d);
    chk("status", 32'h0, d);
    wr(ADDR_CTRL_CNT, 32'hff, RESP_OKAY);
    wait_rst(n);
    chk("win rst", 32'h1, 32'(n <= 4));
    rd(ADDR_STATUS, RESP_OKAY, d);
    chk("status", 32'h82, d);
    $display("test window done");
  endtask : t_win

  task automatic t_soft();
    logic [31:0] d;
    int          n;
    rst_dut();
    wr(ADDR_CTRL_CNT, 32'h80, RESP_OKAY);
    wait_rst(n);
    chk("sw rst", 32'h1, 32'(n <= 4));
    rd(ADDR_STATUS, RESP_OKAY, d);
    chk("status", 32'h84, d);
    wr(ADDR_CTRL_CNT, 32'h7f, RESP_OKAY);
    rd(ADDR_CTRL_CNT, RESP_OKAY, d);
    chk("ctrl", 32'hfe, d & 32'hfe);
    $display("test software done");
  endtask : t_soft

  task automatic t_halt();
    logic [31:0] d;
    int          n;
    rst_dut();
    halt_reset_option <= 1'b1;
    repeat (5) @(posedge aclk);
    hpulse(1'b1);
    hw_activation_option <= 1'b1;
    halt_reset_option <= 1'b0;
    repeat (5) @(posedge aclk);
    wr(ADDR_CTRL_CNT, 32'hff, RESP_OKAY);
    hpulse(1'b1);
    rd(ADDR_STATUS, RESP_OKAY, d);
    chk("status", 32'h0, d);
    halt_reset_option <= 1'b1;
    repeat (5) @(posedge aclk);
    hpulse(1'b0);
    wait_rst(n);
    chk("halt rst", 32'h1, 32'(n <= 4));
    rd(ADDR_STATUS, RESP_OKAY, d);
    chk("status", 32'h88, d);
    hw_activation_option <= 1'b0;
    halt_reset_option <= 1'b0;
    $display("test halt done");
  endtask : t_halt

  task automatic t_calc();
    int          c[5] = '{0, 1, 5, 12, 63};
    logic [31:0] d;
    rst_dut();
    for (int t = 0; t < 4; t++) begin
      for (int k = 0; k < 5; k++) begin
        @(posedge aclk);
        timebase_select <= 2'(t);
        wr(ADDR_CTRL_CNT, 32'h40 | 32'(c[k]), RESP_OKAY);
        rd(ADDR_TOUT_MIN, RESP_OKAY, d);
        chk("tmin", tcalc(t, c[k], 1'b0), d);
        rd(ADDR_TOUT_MAX, RESP_OKAY, d);
        chk("tmax", tcalc(t, c[k], 1'b1), d);
      end
    end
    $display("test timeout calc done");
  endtask : t_calc

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim

  initial begin
    rst_dut();
    t_regs();
    t_tout();
    t_win();
    t_soft();
    t_halt();
    t_calc();
    end_sim();
  end
endmodule : wwd_window_watchdog_timer_tb
`default_nettype wire
